// ==== isa_timing_dram_setup_regs_bench.sv ====
`timescale 1ns/1ps
module isa_timing_dram_setup_regs_bench;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, slow, e;
	logic io16_cycle_end, io8_cycle_end, io16_recovery_busy, io8_recovery_busy;
	logic isa_hold_extend, rom_zero_wait, refresh_request, refresh_cycle_done;
	logic refresh_cycle_start, cas_write_early, cas_read_early, suspend_5v_pin, data_oe;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [7:0] data_out;
	int err_total = 0;
	int cmp_count = 0;
	int l16, l8, base, ex;
	itds_top #(.ADDR_W(12)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .io16_cycle_end, .io8_cycle_end, .io16_recovery_busy,
		.io8_recovery_busy, .isa_hold_extend, .rom_zero_wait, .refresh_request,
		.refresh_cycle_done, .refresh_cycle_start, .cas_write_early, .cas_read_early,
		.suspend_5v_pin, .data_in(8'h00), .data_out, .data_oe);
	itds_isa_model m (.pclk, .slow, .refresh_cycle_start, .refresh_cycle_done);
	// Free-running system clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	task summarize;
		if (err_total == 0 && cmp_count > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("BAD %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	// One transfer; an idle edge after it keeps strobes from toggling twice
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		r = prdata;
		e = pslverr;
		if (pready !== 1'b1) begin
			err_total++;
			summarize();
		end
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task rd(input logic [11:0] a, input logic [31:0] x, input logic xe);
		apb(1'b0, a, 32'h0);
		chk(r, x);
		chk(e, xe);
	endtask
	function automatic int rec(int s, int c);
		return (s != 0 && c != 0) ? c * 4 - 3 : c;
	endfunction
	// Busy length against n ticks of 31.25 clocks, one tick of slack
	function automatic logic near(int l, int n);
		return n == 0 ? l == 0 : (l * 4 - n * 125 <= 132 && n * 125 - l * 4 <= 132);
	endfunction
	initial begin
		{presetn, psel, penable, pwrite, io16_cycle_end, io8_cycle_end} = 6'h00;
		{refresh_request, suspend_5v_pin, slow} = 3'h0;
		paddr = 12'h000;
		pwdata = 32'h0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		rd(12'h054, 32'h00, 1'b0);
		rd(12'h058, 32'h80, 1'b0);
		rd(12'h05C, 32'h00, 1'b0);
		apb(1'b1, 12'h058, 32'hFFFFFF80);
		rd(12'h058, 32'h80, 1'b0);
		apb(1'b1, 12'h05C, 32'hFB);
		rd(12'h05C, 32'h02, 1'b0);
		apb(1'b1, 12'h064, 32'hFF);
		chk(e, 1'b1);
		rd(12'h055, 32'h0, 1'b1);
		apb(1'b1, 12'h054, 32'h80);
		repeat (2) @(posedge pclk);
		chk(isa_hold_extend, 1'b1);
		for (int p = 0; p < 4; p++) begin
			apb(1'b1, 12'h058, {24'h0, 1'b1, p[0], 2'b00, p[1:0], p[1:0]});
			repeat (2) @(posedge pclk);
			chk(rom_zero_wait, p[0]);
			chk(cas_write_early, p == 3);
			chk(cas_read_early, p == 3);
		end
		// Refresh bursts; a slow partner also sees a request dropped mid-burst
		for (int q = 0; q < 4; q++) begin
			apb(1'b1, 12'h058, {24'h0, 2'b10, q[1:0], 4'h0});
			slow <= ~q[1];
			base = m.starts;
			ex = q == 1 ? 2 : q == 3 ? 4 : 1;
			refresh_request <= 1'b1;
			@(posedge pclk);
			refresh_request <= 1'b0;
			repeat (3) @(posedge pclk);
			refresh_request <= slow;
			@(posedge pclk);
			refresh_request <= 1'b0;
			repeat (100) @(posedge pclk);
			chk(m.starts - base, ex);
		end
		// Both recovery fields at once, with different codes
		for (int s = 0; s < 2; s++) for (int c = 0; c < 8; c++) begin
			apb(1'b1, 12'h054, {24'h0, 1'b0, s[0], c[2:0], 3'(7 - c)});
			io16_cycle_end <= 1'b1;
			io8_cycle_end <= 1'b1;
			@(posedge pclk);
			io16_cycle_end <= 1'b0;
			io8_cycle_end <= 1'b0;
			l16 = 0;
			l8 = 0;
			repeat (900) begin
				@(posedge pclk);
				l16 += io16_recovery_busy;
				l8 += io8_recovery_busy;
			end
			chk(near(l16, rec(s, c)), 1'b1);
			chk(near(l8, rec(s, 7 - c)), 1'b1);
			chk(io16_recovery_busy, 1'b0);
			chk(io8_recovery_busy, 1'b0);
		end
		apb(1'b1, 12'h05C, 32'h02);
		suspend_5v_pin <= 1'b1;
		repeat (5) @(posedge pclk);
		chk(data_oe, 1'b1);
		chk(data_out, 8'hFF);
		suspend_5v_pin <= 1'b0;
		repeat (5) @(posedge pclk);
		chk(data_oe, 1'b0);
		suspend_5v_pin <= 1'b1;
		apb(1'b1, 12'h05C, 32'h00);
		repeat (3) @(posedge pclk);
		chk(data_oe, 1'b0);
		summarize();
	end
endmodule // isa_timing_dram_setup_regs_bench

// ==== itds_isa_model.sv ====
`timescale 1ns/1ps
module itds_isa_model (
	input wire logic pclk,
	input wire logic slow,
	input wire logic refresh_cycle_start,
	output logic refresh_cycle_done = 1'b0
);
	int starts = 0;
	int pend = 0;
	// Each refresh cycle ends once, promptly or late; never before its start
	always @(posedge pclk) begin
		refresh_cycle_done <= pend == 1;
		if (pend != 0)
			pend <= pend - 1;
		if (refresh_cycle_start === 1'b1) begin
			starts <= starts + 1;
			pend <= slow ? 9 : 1;
		end
	end
endmodule // itds_isa_model

// ==== itds_pkg.sv ====
package itds_pkg;

	typedef enum logic [0:0] {
		ITDS_RF_IDLE = 1'b0,
		ITDS_RF_WAIT = 1'b1
	} itds_refresh_state_type;

	typedef struct packed {
		logic [7:0] acc;
		logic tick;
	} itds_div_state_type;

	typedef struct packed {
		logic [4:0] count;
		logic busy;
	} itds_timer_state_type;

	typedef struct packed {
		logic [7:0] bus_control;
		logic [7:0] refresh_setup;
		logic [7:0] suspend_control;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
		logic hold_extend;
		logic rom_zero_wait;
		logic cas_write_early;
		logic cas_read_early;
		logic [2:0] refresh_burst;
		itds_refresh_state_type refresh_state;
		logic [2:0] refresh_left;
		logic refresh_start;
		logic rec16_busy;
		logic rec8_busy;
		logic susp_meta;
		logic susp_sync;
		logic [7:0] data_out;
		logic data_oe;
	} itds_top_state_type;

endpackage

// ==== itds_rec_if.sv ====
`timescale 1ns/1ps
interface itds_rec_if;
	logic tick;
	logic start;
	logic [4:0] cycles;
	logic busy;
	modport ctl (output tick, output start, output cycles, input busy);
	modport tmr (input tick, input start, input cycles, output busy);
endinterface // itds_rec_if

// ==== itds_recovery_timer.sv ====
`timescale 1ns/1ps
module itds_recovery_timer (
	input wire logic pclk,
	input wire logic presetn,
	itds_rec_if.tmr rec
);
	import itds_pkg::*;

	itds_timer_state_type st;
	itds_timer_state_type next_st;

	// A new start reloads even while counting; ticks pace the countdown
	always_comb begin
		next_st = st;
		if (rec.start) begin
			next_st.count = rec.cycles;
		end else if (rec.tick && st.count != 5'h00) begin
			next_st.count = st.count - 5'h01;
		end
		next_st.busy = (next_st.count != 5'h00);
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign rec.busy = st.busy;
endmodule // itds_recovery_timer

// ==== itds_regs.svh ====
`ifndef ITDS_REGS_SVH
`define ITDS_REGS_SVH

// Register indices; byte address is four times the index
`define ITDS_IDX_BUS_CONTROL 8'h15
`define ITDS_IDX_REFRESH_SETUP 8'h16
`define ITDS_IDX_SUSPEND 8'h17

// Reset values
`define ITDS_RST_BUS_CONTROL 8'h00
`define ITDS_RST_REFRESH_SETUP 8'h80
`define ITDS_RST_SUSPEND 8'h00

// Software-writable bits
`define ITDS_WMASK_BUS_CONTROL 8'hFF
`define ITDS_WMASK_REFRESH_SETUP 8'h7F
`define ITDS_WMASK_SUSPEND 8'h02

// Bus control fields
`define ITDS_HOLD_BIT 7
`define ITDS_SCALE_BIT 6
`define ITDS_REC16_MSB 5
`define ITDS_REC16_LSB 3
`define ITDS_REC8_MSB 2
`define ITDS_REC8_LSB 0

// Refresh and DRAM setup fields
`define ITDS_ROM_ZW_BIT 6
`define ITDS_RBURST_HI 5
`define ITDS_RBURST_LO 4
`define ITDS_CASW_HI 3
`define ITDS_CASW_LO 2
`define ITDS_CASR_HI 1
`define ITDS_CASR_LO 0

// Suspend control fields
`define ITDS_SUSP_DRIVE_BIT 1
`define ITDS_SUSP_DATA_LEVEL 8'hFF

// Refresh burst lengths
`define ITDS_RBURST_ONE 3'h1
`define ITDS_RBURST_TWO 3'h2
`define ITDS_RBURST_FOUR 3'h4

// Slow recovery: cycles = code * STEP - OFFSET for nonzero code
`define ITDS_SLOW_STEP 3'h4
`define ITDS_SLOW_OFFSET 5'h03

// Timing: system clock and recovery unit rates
`define ITDS_SYS_CLK_MHZ 250
`define ITDS_REC_UNIT_MHZ 8

`endif

// ==== itds_tick_div.sv ====
`timescale 1ns/1ps
`include "itds_regs.svh"
module itds_tick_div #(
	parameter int CLK_MHZ = `ITDS_SYS_CLK_MHZ,
	parameter int TICK_MHZ = `ITDS_REC_UNIT_MHZ
) (
	input wire logic pclk,
	input wire logic presetn,
	output logic tick
);
	import itds_pkg::*;

	// Accumulator must fit eight bits and the tick be slower than the clock
	generate
		if (CLK_MHZ > 255 || TICK_MHZ < 1 || TICK_MHZ >= CLK_MHZ) begin : g_bad
			$error("itds_tick_div: unsupported rates");
		end
	endgenerate

	itds_div_state_type st;
	itds_div_state_type next_st;

	// Fractional divider: average tick rate is exact, jitter is one clock
	always_comb begin
		logic [8:0] sum;
		sum = {1'b0, st.acc} + 9'(TICK_MHZ);
		next_st = st;
		next_st.tick = 1'b0;
		if (sum >= 9'(CLK_MHZ)) begin
			next_st.acc = 8'(sum - 9'(CLK_MHZ));
			next_st.tick = 1'b1;
		end else begin
			next_st.acc = sum[7:0];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	assign tick = st.tick;
endmodule // itds_tick_div

// ==== itds_top.sv ====
// Design decision made here: register access over APB.
`timescale 1ns/1ps
`include "itds_regs.svh"

module itds_top #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic io16_cycle_end,
	input wire logic io8_cycle_end,
	output logic io16_recovery_busy,
	output logic io8_recovery_busy,
	output logic isa_hold_extend,
	output logic rom_zero_wait,
	input wire logic refresh_request,
	input wire logic refresh_cycle_done,
	output logic refresh_cycle_start,
	output logic cas_write_early,
	output logic cas_read_early,
	input wire logic suspend_5v_pin,
	input wire logic [7:0] data_in,
	output logic [7:0] data_out,
	output logic data_oe
);
	import itds_pkg::*;

	// Decoder needs the highest index plus two byte-offset bits
	generate
		if (ADDR_W < 10 || ADDR_W > 32) begin : g_bad
			$error("itds_top: ADDR_W out of range");
		end
	endgenerate

	itds_top_state_type st;
	itds_top_state_type next_st;

	itds_rec_if rec16 ();
	itds_rec_if rec8 ();
	logic tick_8mhz;

	// Recovery unit tick, shared by both timers
	itds_tick_div #(
		.CLK_MHZ(`ITDS_SYS_CLK_MHZ),
		.TICK_MHZ(`ITDS_REC_UNIT_MHZ)
	) u_div (
		.pclk(pclk),
		.presetn(presetn),
		.tick(tick_8mhz)
	);

	itds_recovery_timer u_rec16 (
		.pclk(pclk),
		.presetn(presetn),
		.rec(rec16.tmr)
	);

	itds_recovery_timer u_rec8 (
		.pclk(pclk),
		.presetn(presetn),
		.rec(rec8.tmr)
	);

	// Map a 3-bit recovery code to a count of 8 MHz periods
	function automatic logic [4:0] rec_cycles(input logic [2:0] code, input logic slow);
		logic [4:0] prod;
		prod = 5'(code * `ITDS_SLOW_STEP);
		if (!slow || code == 3'h0) begin
			rec_cycles = {2'b00, code};
		end else begin
			rec_cycles = prod - `ITDS_SLOW_OFFSET;
		end
	endfunction

	// Refresh burst length from bits 5:4
	function automatic logic [2:0] burst_len(input logic hi, input logic lo);
		if (!lo) begin
			burst_len = `ITDS_RBURST_ONE;
		end else if (!hi) begin
			burst_len = `ITDS_RBURST_TWO;
		end else begin
			burst_len = `ITDS_RBURST_FOUR;
		end
	endfunction

	// Recovery timers start on the end of each I/O cycle
	assign rec16.tick = tick_8mhz;
	assign rec16.start = io16_cycle_end;
	assign rec16.cycles = rec_cycles(st.bus_control[`ITDS_REC16_MSB:`ITDS_REC16_LSB],
		st.bus_control[`ITDS_SCALE_BIT]);
	assign rec8.tick = tick_8mhz;
	assign rec8.start = io8_cycle_end;
	assign rec8.cycles = rec_cycles(st.bus_control[`ITDS_REC8_MSB:`ITDS_REC8_LSB],
		st.bus_control[`ITDS_SCALE_BIT]);

	// Next-state logic for bus slave, controls, refresh and suspend
	always_comb begin
		logic access;
		logic commit;
		logic aligned;
		logic [ADDR_W-3:0] word;
		logic hit_bus;
		logic hit_refresh;
		logic hit_suspend;
		logic [31:0] rdata;
		access = psel && penable;
		commit = access && st.pready;
		aligned = (paddr[1:0] == 2'b00);
		word = paddr[ADDR_W-1:2];
		hit_bus = aligned && word == (ADDR_W-2)'(`ITDS_IDX_BUS_CONTROL);
		hit_refresh = aligned && word == (ADDR_W-2)'(`ITDS_IDX_REFRESH_SETUP);
		hit_suspend = aligned && word == (ADDR_W-2)'(`ITDS_IDX_SUSPEND);
		rdata = 32'h00000000;
		next_st = st;

		// Read view; reserved bits come from the stored constant values
		if (hit_bus) begin
			rdata = {24'h000000, st.bus_control};
		end else if (hit_refresh) begin
			rdata = {24'h000000, st.refresh_setup};
		end else if (hit_suspend) begin
			rdata = {24'h000000, st.suspend_control};
		end

		// One wait state: ready rises at the end of the first access cycle, falls after
		next_st.pready = 1'b0;
		next_st.pslverr = 1'b0;
		if (access && !st.pready) begin
			next_st.pready = 1'b1;
			next_st.pslverr = !(hit_bus || hit_refresh || hit_suspend);
			next_st.prdata = pwrite ? 32'h00000000 : rdata;
		end

		// Writes land only at the completing edge; reserved bits keep value
		if (commit && pwrite) begin
			if (hit_bus) begin
				next_st.bus_control = pwdata[7:0] & `ITDS_WMASK_BUS_CONTROL;
			end
			if (hit_refresh) begin
				next_st.refresh_setup = (pwdata[7:0] & `ITDS_WMASK_REFRESH_SETUP) |
					(st.refresh_setup & ~`ITDS_WMASK_REFRESH_SETUP);
			end
			if (hit_suspend) begin
				next_st.suspend_control = (pwdata[7:0] & `ITDS_WMASK_SUSPEND) |
					(st.suspend_control & ~`ITDS_WMASK_SUSPEND);
			end
		end

		// Decoded controls follow the stored fields one cycle later
		next_st.hold_extend = st.bus_control[`ITDS_HOLD_BIT];
		next_st.rom_zero_wait = st.refresh_setup[`ITDS_ROM_ZW_BIT];
		next_st.cas_write_early = st.refresh_setup[`ITDS_CASW_HI] &&
			st.refresh_setup[`ITDS_CASW_LO];
		next_st.cas_read_early = st.refresh_setup[`ITDS_CASR_HI] &&
			st.refresh_setup[`ITDS_CASR_LO];
		next_st.refresh_burst = burst_len(st.refresh_setup[`ITDS_RBURST_HI],
			st.refresh_setup[`ITDS_RBURST_LO]);
		next_st.rec16_busy = rec16.busy;
		next_st.rec8_busy = rec8.busy;

		// Refresh burst: requests arriving mid-burst are dropped
		next_st.refresh_start = 1'b0;
		case (st.refresh_state)
			ITDS_RF_IDLE: begin
				if (refresh_request) begin
					next_st.refresh_left = st.refresh_burst;
					next_st.refresh_start = 1'b1;
					next_st.refresh_state = ITDS_RF_WAIT;
				end
			end
			ITDS_RF_WAIT: begin
				if (refresh_cycle_done) begin
					if (st.refresh_left > 3'h1) begin
						next_st.refresh_left = st.refresh_left - 3'h1;
						next_st.refresh_start = 1'b1;
					end else begin
						next_st.refresh_left = 3'h0;
						next_st.refresh_state = ITDS_RF_IDLE;
					end
				end
			end
			default: begin
				next_st.refresh_state = ITDS_RF_IDLE;
			end
		endcase

		// Suspend pin is asynchronous: two flops before use
		next_st.susp_meta = suspend_5v_pin;
		next_st.susp_sync = st.susp_meta;
		next_st.data_oe = st.susp_sync && st.suspend_control[`ITDS_SUSP_DRIVE_BIT];
		next_st.data_out = `ITDS_SUSP_DATA_LEVEL;
	end

	// Single state register; reset loads documented defaults
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st <= '0;
			st.bus_control <= `ITDS_RST_BUS_CONTROL;
			st.refresh_setup <= `ITDS_RST_REFRESH_SETUP;
			st.suspend_control <= `ITDS_RST_SUSPEND;
			st.refresh_burst <= `ITDS_RBURST_ONE;
			st.refresh_state <= ITDS_RF_IDLE;
			st.data_out <= `ITDS_SUSP_DATA_LEVEL;
		end else begin
			st <= next_st;
		end
	end

	// Data input is only sampled by the memory path, not here
	logic unused_data;
	assign unused_data = ^data_in;

	// Outputs straight from the state register
	assign prdata = st.prdata;
	assign pready = st.pready;
	assign pslverr = st.pslverr;
	assign io16_recovery_busy = st.rec16_busy;
	assign io8_recovery_busy = st.rec8_busy;
	assign isa_hold_extend = st.hold_extend;
	assign rom_zero_wait = st.rom_zero_wait;
	assign refresh_cycle_start = st.refresh_start;
	assign cas_write_early = st.cas_write_early;
	assign cas_read_early = st.cas_read_early;
	assign data_out = st.data_out;
	assign data_oe = st.data_oe;
endmodule // itds_top

// ==== itds_top_checker.sv ====
`timescale 1ns/1ps
module itds_top_checker #(
	parameter int ADDR_W = 12
) (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic isa_hold_extend,
	input wire logic rom_zero_wait,
	input wire logic cas_write_early,
	input wire logic cas_read_early,
	input wire logic [7:0] data_out,
	input wire logic data_oe,
	input wire logic suspend_5v_pin
);
	localparam logic [ADDR_W-1:0] A15 = ADDR_W'(12'h054);
	localparam logic [ADDR_W-1:0] A16 = ADDR_W'(12'h058);
	localparam logic [ADDR_W-1:0] A17 = ADDR_W'(12'h05C);
	logic wr;
	logic rd;
	logic mapped;
	// Completed transfers; decoded outputs lag a write by two edges
	assign wr = psel && penable && pready && pwrite;
	assign rd = psel && penable && pready && !pwrite;
	assign mapped = paddr == A15 || paddr == A16 || paddr == A17;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	a_hold_write: assert property (wr && paddr == A15 |-> ##2
		isa_hold_extend == $past(pwdata[7], 2))
		else $error("hold extend does not follow write");
	a_rom_write: assert property (wr && paddr == A16 |-> ##2
		rom_zero_wait == $past(pwdata[6], 2))
		else $error("rom zero wait does not follow write");
	a_casw_write: assert property (wr && paddr == A16 |-> ##2
		cas_write_early == ($past(pwdata[3], 2) && $past(pwdata[2], 2)))
		else $error("write cas extension wrong");
	a_casr_write: assert property (wr && paddr == A16 |-> ##2
		cas_read_early == ($past(pwdata[1], 2) && $past(pwdata[0], 2)))
		else $error("read cas extension wrong");
	a_one_wait: assert property (psel && !penable |=> !pready ##1 pready)
		else $error("apb answer not after one wait state");
	a_err_decode: assert property (pready |-> pslverr == !mapped && (mapped || prdata == 32'h0))
		else $error("bus error does not match address");
	a_fixed_one: assert property (rd && paddr == A16 |-> prdata[7] && prdata[31:8] == 24'h0)
		else $error("refresh setup bit 7 not one");
	a_susp_zero: assert property (rd && paddr == A17 |-> prdata[31:2] == 30'h0 && !prdata[0])
		else $error("suspend reserved bits not zero");
	a_drive_high: assert property (data_oe |-> data_out == 8'hFF)
		else $error("data pins driven low in suspend");
	// Pin passes two sync flops and the output flop before the drive enable
	a_oe_after_pin: assert property (data_oe |-> $past(suspend_5v_pin, 3))
		else $error("data pins driven without suspend pin");
endmodule // itds_top_checker

bind itds_top itds_top_checker #(.ADDR_W(ADDR_W)) chk_i (.pclk, .presetn, .psel, .penable, .pwrite,
	.paddr, .pwdata, .prdata, .pready, .pslverr, .isa_hold_extend, .rom_zero_wait,
	.cas_write_early, .cas_read_early, .data_out, .data_oe, .suspend_5v_pin);
